// ---- verilog/gpc_pkg.sv ----
// Purpose: shared constants and types of the two-port gpio block
// Assumes: 32-bit ahb-lite register bus, word registers at index * 4
// Notes: register indices are kept as printed; byte address is index * 4
package gpc_pkg;

  // port width and register index width
  localparam int GPC_W = 8;
  localparam int IDX_W = 8;
  localparam int ADDR_LSB = 2;

  // register indices (byte address = index * 4)
  localparam logic [IDX_W-1:0] IDX_B_DATA = 8'h06;
  localparam logic [IDX_W-1:0] IDX_C_DATA = 8'h07;
  localparam logic [IDX_W-1:0] IDX_IRQ_CTRL = 8'h0b;
  localparam logic [IDX_W-1:0] IDX_OPTION = 8'h81;
  localparam logic [IDX_W-1:0] IDX_B_DIR = 8'h86;
  localparam logic [IDX_W-1:0] IDX_C_DIR = 8'h87;

  // reset values
  localparam logic [GPC_W-1:0] DIR_RST = 8'hff;
  localparam logic [GPC_W-1:0] OPTION_RST = 8'hff;
  localparam logic [GPC_W-1:0] LATCH_POR = 8'h00;
  localparam logic [GPC_W-1:0] READ_ZERO = 8'h00;

  // field positions
  localparam int OPT_PULLUP_N_BIT = 7;
  localparam int ICR_GIE_BIT = 7;
  localparam int ICR_CIE_BIT = 3;
  localparam int ICR_FLAG_BIT = 0;
  localparam int WATCH_LO = 4;
  localparam int WATCH_HI = 7;
  localparam int WATCH_W = WATCH_HI - WATCH_LO + 1;

  // ahb-lite encodings
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [23:0] HRDATA_PAD = 24'h000000;

  // drive of one port towards its pads
  typedef struct packed {
    logic [GPC_W-1:0] level;
    logic [GPC_W-1:0] enable;
  } gpc_drive_t;

  // captured address phase
  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic write;
  } gpc_req_t;

  // bus data-phase states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ_WAIT,
    ST_READ_DONE
  } gpc_phase_t;

  // word address to register index
  function automatic logic [IDX_W-1:0] gpc_index(input logic [31:0] addr);
    return addr[ADDR_LSB +: IDX_W];
  endfunction

endpackage

// ---- verilog/gpc_port.sv ----
// Purpose: one parallel port: output latch and direction register
// Assumes: strobes are single-cycle, write data valid with the strobe
// Notes: latch is cleared only by power-on, never by other resets
`timescale 1ns/1ps
module gpc_port import gpc_pkg::*; #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic por_n,
  input wire logic wr_data,
  input wire logic wr_dir,
  input wire logic [WIDTH-1:0] wdata,
  output gpc_drive_t drive,
  output logic [WIDTH-1:0] dir
);

  // the drive struct is fixed at the package width
  if (WIDTH != GPC_W) begin
    // refused at elaboration, not at run time
    $error("gpc_port: WIDTH must equal GPC_W");
  end

  logic [WIDTH-1:0] latch; // output data latch

  // latch keeps its content over non-power-on resets
  always_ff @(posedge clk) begin
    if (!por_n) begin
      latch <= LATCH_POR;
    end else if (wr_data) begin
      latch <= wdata; // a write loads the latch, not the pins
    end
  end

  // direction: one means input, every reset makes all pins inputs
  always_ff @(posedge clk) begin
    if (!nrst || !por_n) begin
      dir <= DIR_RST;
    end else if (wr_dir) begin
      dir <= wdata;
    end
  end

  // a set direction bit floats the driver, clear drives the latch
  assign drive.level = latch;
  assign drive.enable = ~dir;

endmodule

// ---- verilog/gpc_top.sv ----
// Purpose: two gpio ports with change detection behind ahb-lite
// Assumes: pins synchronous to SYS_CLK, POR_N low with NRST at power-on
// Notes: writes zero wait, reads one wait state, response always okay
//
// Notes on behaviour
// - port b: eight pins, each with direction bit
// - direction one floats pin, zero drives latch
// - port b read gives pins, write loads latch
// - writes sample pins first, then store latch
// - pull-ups on while option bit 7 clear
// - output pins never get a pull-up
// - pull-ups off after power-on reset
// - only upper four input pins watched
// - mismatch with value sampled at last port b access sets flag
// - persisting mismatch keeps setting the flag
// - port b access refreshes reference; software clears flag
// - change during a read may be missed
// - port c: eight pins, own direction register
// - port c: same direction, read, write behaviour
`timescale 1ns/1ps
module gpc_top import gpc_pkg::*; #(
  parameter int WIDTH = 8
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic POR_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [WIDTH-1:0] GPIO_B_IN,
  output logic [WIDTH-1:0] GPIO_B_OUT,
  output logic [WIDTH-1:0] GPIO_B_OE,
  output logic [WIDTH-1:0] GPIO_B_PULLUP,
  input wire logic [WIDTH-1:0] GPIO_C_IN,
  output logic [WIDTH-1:0] GPIO_C_OUT,
  output logic [WIDTH-1:0] GPIO_C_OE,
  output logic CHANGE_IRQ
);

  // register fields are fixed at the package width
  if (WIDTH != GPC_W) begin
    // refused at elaboration, not at run time
    $error("gpc_top: WIDTH must equal GPC_W");
  end

  // bus state
  gpc_phase_t phase; // current data phase
  gpc_phase_t next_phase; // data phase after this edge
  gpc_req_t req; // address phase held for the data phase
  logic accept; // address phase taken at this edge

  // register state
  logic [WIDTH-1:0] option; // pull-up option, only bit 7 used
  logic global_irq_enable; // master interrupt gate
  logic change_irq_enable; // change interrupt gate
  logic change_irq_flag; // sticky change flag
  logic [WATCH_W-1:0] change_ref; // pins seen at last port b access
  logic [WATCH_W-1:0] mismatch; // per-pin change indication
  logic [WIDTH-1:0] rd_value; // selected register for a read

  // port views
  gpc_drive_t drive_b; // port b pad drive
  gpc_drive_t drive_c; // port c pad drive
  logic [WIDTH-1:0] dir_b; // port b direction
  logic [WIDTH-1:0] dir_c; // port c direction

  // write strobes, all in the write data phase
  logic wr_b_data;
  logic wr_c_data;
  logic wr_b_dir;
  logic wr_c_dir;
  logic wr_option;
  logic wr_irq_ctrl;
  logic rd_b_data; // port b read sampled this edge

  // bus handshake
  // one slave, so hreadyout returns as the bus hready
  // ahb size is ignored: only whole-word transfers are expected
  assign accept = HSEL && HTRANS[HTRANS_ACTIVE_BIT] && HREADY;
  assign HREADYOUT = (phase != ST_READ_WAIT);
  assign HRESP = HRESP_OKAY;

  // data-phase sequencing
  always_comb begin
    next_phase = ST_IDLE;
    if (phase == ST_READ_WAIT) begin
      // the wait lets a previous write land before sampling
      next_phase = ST_READ_DONE;
    end else if (accept) begin
      next_phase = HWRITE ? ST_WRITE : ST_READ_WAIT;
    end
  end

  // phase register
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      phase <= ST_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // address phase capture
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      req <= '0;
    end else if (accept) begin
      req.idx <= gpc_index(HADDR);
      req.write <= HWRITE;
    end
  end

  // write decode: unmapped indices simply store nothing
  assign wr_b_data = (phase == ST_WRITE) && (req.idx == IDX_B_DATA);
  assign wr_c_data = (phase == ST_WRITE) && (req.idx == IDX_C_DATA);
  assign wr_b_dir = (phase == ST_WRITE) && (req.idx == IDX_B_DIR);
  assign wr_c_dir = (phase == ST_WRITE) && (req.idx == IDX_C_DIR);
  assign wr_option = (phase == ST_WRITE) && (req.idx == IDX_OPTION);
  assign wr_irq_ctrl = (phase == ST_WRITE) && (req.idx == IDX_IRQ_CTRL);
  assign rd_b_data = (phase == ST_READ_WAIT) && (req.idx == IDX_B_DATA);

  // ports
  // both ports take the low byte of the write data
  // the bus writes whole bytes, so the modify step of read-modify-write
  // is done by software; the pins are still sampled on the write
  gpc_port #(.WIDTH(WIDTH)) u_port_b (
    .clk(SYS_CLK),
    .nrst(NRST),
    .por_n(POR_N),
    .wr_data(wr_b_data),
    .wr_dir(wr_b_dir),
    .wdata(HWDATA[WIDTH-1:0]),
    .drive(drive_b),
    .dir(dir_b)
  );

  gpc_port #(.WIDTH(WIDTH)) u_port_c (
    .clk(SYS_CLK),
    .nrst(NRST),
    .por_n(POR_N),
    .wr_data(wr_c_data),
    .wr_dir(wr_c_dir),
    .wdata(HWDATA[WIDTH-1:0]),
    .drive(drive_c),
    .dir(dir_c)
  );

  // pad outputs
  assign GPIO_B_OUT = drive_b.level;
  assign GPIO_B_OE = drive_b.enable;
  assign GPIO_C_OUT = drive_c.level;
  assign GPIO_C_OE = drive_c.enable;

  // pull-ups: shared active-low enable, gated off on outputs
  assign GPIO_B_PULLUP = {WIDTH{~option[OPT_PULLUP_N_BIT]}}
                         & dir_b;

  // option register, all ones after any reset
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || !POR_N) begin
      option <= OPTION_RST; // pull-ups start off
    end else if (wr_option) begin
      option <= HWDATA[WIDTH-1:0];
    end
  end

  // change detection
  // only the upper four port b pins are watched
  // outputs among the watched pins never compare
  assign mismatch = (GPIO_B_IN[WATCH_HI:WATCH_LO] ^ change_ref)
                    & ~drive_b.enable[WATCH_HI:WATCH_LO];

  // reference follows every port b read or write; the read samples
  // the same pins it returns, so a change in that cycle may be lost
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      change_ref <= '0;
    end else if (rd_b_data || wr_b_data) begin
      change_ref <= GPIO_B_IN[WATCH_HI:WATCH_LO];
    end
  end

  // sticky flag: a live mismatch beats a software clear
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      change_irq_flag <= 1'b0;
    end else if (|mismatch) begin
      change_irq_flag <= 1'b1;
    end else if (wr_irq_ctrl) begin
      // software may only clear, never set
      change_irq_flag <= change_irq_flag & HWDATA[ICR_FLAG_BIT];
    end
  end

  // interrupt enables
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      global_irq_enable <= 1'b0;
      change_irq_enable <= 1'b0;
    end else if (wr_irq_ctrl) begin
      global_irq_enable <= HWDATA[ICR_GIE_BIT];
      change_irq_enable <= HWDATA[ICR_CIE_BIT];
    end
  end

  // request needs the flag and both enables
  assign CHANGE_IRQ = change_irq_flag && change_irq_enable
                      && global_irq_enable;

  // read path
  // a read is answered after one wait state
  // data registers return live pin levels, not the latch
  always_comb begin
    rd_value = READ_ZERO;
    unique case (req.idx)
      IDX_B_DATA: rd_value = GPIO_B_IN;
      IDX_C_DATA: rd_value = GPIO_C_IN;
      IDX_IRQ_CTRL: begin
        rd_value[ICR_GIE_BIT] = global_irq_enable;
        rd_value[ICR_CIE_BIT] = change_irq_enable;
        rd_value[ICR_FLAG_BIT] = change_irq_flag;
      end
      IDX_OPTION: rd_value = option;
      IDX_B_DIR: rd_value = dir_b;
      IDX_C_DIR: rd_value = dir_c;
      default: rd_value = READ_ZERO; // unmapped reads as zero
    endcase
  end

  // read data is registered at the end of the wait cycle
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      HRDATA <= '0;
    end else if (phase == ST_READ_WAIT) begin
      HRDATA <= {HRDATA_PAD, rd_value};
    end
  end

  // checks
  // assertions on what the block itself drives
  a_dir_reset: assert property (
    @(posedge SYS_CLK) !NRST |=> (dir_b == DIR_RST) && (dir_c == DIR_RST))
    else $error("direction not all inputs after reset");

  a_dir_drive: assert property (
    @(posedge SYS_CLK) disable iff (!NRST || !POR_N)
    wr_b_dir |=> GPIO_B_OE == ~$past(HWDATA[WIDTH-1:0]))
    else $error("port b enable does not follow direction write");

  a_latch_write: assert property (
    @(posedge SYS_CLK) disable iff (!NRST || !POR_N)
    wr_b_data |=> GPIO_B_OUT == $past(HWDATA[WIDTH-1:0]))
    else $error("port b latch not loaded by write");

  a_c_latch: assert property (
    @(posedge SYS_CLK) disable iff (!NRST || !POR_N)
    wr_c_data |=> GPIO_C_OUT == $past(HWDATA[WIDTH-1:0]))
    else $error("port c latch not loaded by write");

  a_read_pins: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rd_b_data |=> HREADYOUT && HRDATA[WIDTH-1:0] == $past(GPIO_B_IN))
    else $error("port b read does not return pin levels");

  a_read_wait: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (accept && !HWRITE) |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");

  a_pullup_off: assert property (
    @(posedge SYS_CLK) (GPIO_B_PULLUP & GPIO_B_OE) == '0)
    else $error("pull-up active on an output pin");

  a_pullup_cmd: assert property (
    @(posedge SYS_CLK) disable iff (!NRST || !POR_N)
    (wr_option && !HWDATA[OPT_PULLUP_N_BIT]) |=> GPIO_B_PULLUP == dir_b)
    else $error("pull-ups not enabled by cleared control bit");

  a_pullup_por: assert property (
    @(posedge SYS_CLK) !POR_N |=> GPIO_B_PULLUP == '0)
    else $error("pull-ups on after power-on reset");

  a_change_set: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (|mismatch) |=> change_irq_flag)
    else $error("mismatch did not set change flag");

  a_ref_refresh: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    rd_b_data |=> change_ref == $past(GPIO_B_IN[WATCH_HI:WATCH_LO]))
    else $error("reference not refreshed by port b read");

  a_irq_gate: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    $rose(CHANGE_IRQ) |-> change_irq_flag && change_irq_enable
    && global_irq_enable && $past(wr_irq_ctrl || |mismatch))
    else $error("interrupt request without its cause");

endmodule

// ---- test/gpc_pin_model.sv ----
// Purpose: pad and keypad model for one eight-pin port
// Assumes: outside drivers are ideal, pull-ups are weak
// Notes: a pad nobody drives toggles, so no stale level is read
`timescale 1ns/1ps
module gpc_pin_model (
  input wire logic clk,
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  input wire logic [7:0] pu_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin
);
  // level seen one cycle ago, used for floating pads
  logic [7:0] last;

  // remember the pad level
  always_ff @(posedge clk) begin
    last <= pin;
  end

  // resolve each pad: own driver, outside driver, pull-up, float
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe[i]) begin
        pin[i] = out[i];
      end else if (ext_en[i]) begin
        pin[i] = ext_val[i];
      end else if (pu_en[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = ~last[i]; // floating, changes every cycle
      end
    end
  end
endmodule

// ---- test/gpio_ports_with_change_irq_tb.sv ----
// Purpose: self-checking bench for the two-port gpio block
// Assumes: one ahb-lite slave, hready fed back from hreadyout
// Notes: register byte address is the index times four
`timescale 1ns/1ps
module gpio_ports_with_change_irq_tb import gpc_pkg::*; ;
  // clock, resets and bus
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic por_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  // pads and outside drivers
  logic [7:0] b_in, b_out, b_oe, b_pu, c_in, c_out, c_oe;
  logic [7:0] b_ev = 8'h3c;
  logic [7:0] b_ee = 8'hff;
  logic [7:0] c_ev = 8'h5a;
  logic [7:0] c_ee = 8'hff;
  logic irq;
  int n_fail = 0;
  int checks_done = 0;

  // 40 mhz clock
  always #12.5 sys_clk = ~sys_clk;

  gpc_top dut (.SYS_CLK(sys_clk), .NRST(nrst), .POR_N(por_n),
    .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .GPIO_B_IN(b_in), .GPIO_B_OUT(b_out), .GPIO_B_OE(b_oe),
    .GPIO_B_PULLUP(b_pu), .GPIO_C_IN(c_in), .GPIO_C_OUT(c_out),
    .GPIO_C_OE(c_oe), .CHANGE_IRQ(irq));
  gpc_pin_model pm_b (.clk(sys_clk), .out(b_out), .oe(b_oe),
    .pu_en(b_pu), .ext_val(b_ev), .ext_en(b_ee), .pin(b_in));
  // port c has no pull-ups
  gpc_pin_model pm_c (.clk(sys_clk), .out(c_out), .oe(c_oe),
    .pu_en(8'h00), .ext_val(c_ev), .ext_en(c_ee), .pin(c_in));

  // verdict and end of run
  task end_sim;
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // compare seen against expected
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task tick;
    @(posedge sys_clk);
  endtask

  // one single transfer; waits on hready, never on a fixed count
  task xfer(input logic wr, input logic [7:0] idx,
            input logic [7:0] wd, output logic [7:0] rd);
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    tick;
    while (hready !== 1'b1) tick;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    tick;
    while (hready !== 1'b1) tick;
    rd = hrdata[7:0];
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] junk;
    xfer(1'b1, idx, d, junk);
  endtask

  // read a register and compare it
  task rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    xfer(1'b0, idx, 8'h00, d);
    check(d, exp);
    check({7'h00, hresp}, {7'h00, HRESP_OKAY});
  endtask

  // watchdog, far beyond the roughly 140 cycles the run needs
  initial begin
    repeat (5000) tick;
    n_fail++;
    end_sim;
  end

  // main sequence
  initial begin
    repeat (20) tick;
    nrst <= 1'b1;
    por_n <= 1'b1;
    tick;
    // power-on values
    rdc(IDX_B_DIR, DIR_RST);
    rdc(IDX_C_DIR, DIR_RST);
    rdc(IDX_OPTION, OPTION_RST);
    // pins differ from the cleared reference, so the flag may be up;
    // a port b read moves the reference, then a write clears the flag
    rdc(IDX_B_DATA, 8'h3c);
    wr(IDX_IRQ_CTRL, 8'h00);
    rdc(IDX_IRQ_CTRL, 8'h00);
    check(b_pu, 8'h00);
    check(b_oe, 8'h00);
    check(b_out, LATCH_POR);
    // unmapped place: write ignored, reads zero
    wr(8'h05, 8'hff);
    rdc(8'h05, READ_ZERO);
    // lower pins out, upper in; back-to-back write then read
    wr(IDX_B_DIR, 8'hf0);
    wr(IDX_B_DATA, 8'ha5);
    rdc(IDX_B_DATA, 8'h35);
    check(b_out, 8'ha5);
    check(b_oe, 8'h0f);
    // pull-ups only on input pins
    wr(IDX_OPTION, 8'h7f);
    tick;
    check(b_pu, 8'hf0);
    b_ee <= 8'h0f;
    tick;
    rdc(IDX_B_DATA, 8'hf5);
    // drive again before pull-ups go, so nothing floats
    b_ee <= 8'hff;
    b_ev <= 8'h30;
    wr(IDX_OPTION, OPTION_RST);
    tick;
    check(b_pu, 8'h00);
    // change detection; no port b reads while waiting
    rdc(IDX_B_DATA, 8'h35);
    wr(IDX_IRQ_CTRL, 8'h88);
    repeat (3) tick;
    rdc(IDX_IRQ_CTRL, 8'h88);
    b_ev <= 8'hb0;
    repeat (3) tick;
    rdc(IDX_IRQ_CTRL, 8'h89);
    check({7'h00, irq}, 8'h01);
    // clear while mismatch persists does not stick
    wr(IDX_IRQ_CTRL, 8'h88);
    tick;
    rdc(IDX_IRQ_CTRL, 8'h89);
    rdc(IDX_B_DATA, 8'hb5);
    wr(IDX_IRQ_CTRL, 8'h88);
    tick;
    rdc(IDX_IRQ_CTRL, 8'h88);
    check({7'h00, irq}, 8'h00);
    // every enable pair with the flag held set
    b_ev <= 8'h30;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_IRQ_CTRL, {i[1], 3'b000, i[0], 3'b001});
      tick;
      check({7'h00, irq}, {7'h00, i == 3});
    end
    rdc(IDX_B_DATA, 8'h35);
    wr(IDX_IRQ_CTRL, 8'h00);
    // pin 4 turned output and lower pins changing: no flag
    wr(IDX_B_DIR, 8'hef);
    repeat (3) tick;
    rdc(IDX_IRQ_CTRL, 8'h00);
    b_ev <= 8'h3f;
    repeat (3) tick;
    rdc(IDX_IRQ_CTRL, 8'h00);
    rdc(IDX_B_DATA, 8'h2f);
    // port c: upper out, lower in
    wr(IDX_C_DIR, 8'h0f);
    wr(IDX_C_DATA, 8'hc3);
    tick;
    check(c_out, 8'hc3);
    check(c_oe, 8'hf0);
    rdc(IDX_C_DATA, 8'hca);
    // reset without power-on: latches kept, directions back
    nrst <= 1'b0;
    tick;
    tick;
    nrst <= 1'b1;
    tick;
    check(b_out, 8'ha5);
    check(c_out, 8'hc3);
    check(c_oe, 8'h00);
    rdc(IDX_B_DIR, DIR_RST);
    end_sim;
  end
endmodule
